//--- tpioc_regs.svh
// Constants for the timer pin I/O control block.
// Assumes a 25 MHz device clock and a plain strobe-based register port.
`ifndef TPIOC_REGS_SVH
`define TPIOC_REGS_SVH
`define TPIOC_ADDR_W 4
`define TPIOC_OFF_SELECT 4'h0
`define TPIOC_OFF_GPIO_OUT 4'h4
`define TPIOC_OFF_GPIO_IN 4'h8
`define TPIOC_OFF_PERIOD0 4'hc
`define TPIOC_OFF_COUNT0 4'hd
`define TPIOC_OFF_PERIOD1 4'he
`define TPIOC_OFF_COUNT1 4'hf
`define TPIOC_SEL_W 4
`define TPIOC_SEL_RESET 4'h0
`define TPIOC_PERIOD_RESET 16'hffff
`endif

//--- tpioc_pkg.sv
// Types for the timer pin I/O control block.
// Assumes the constants header is included beside it.
package tpioc_pkg;
  // Per-pin function: GPIO input default, GPIO output, timer out, timer in.
  typedef enum logic [1:0] {
    TPIOC_GPIO_IN,
    TPIOC_GPIO_OUT,
    TPIOC_TIM_OUT,
    TPIOC_TIM_IN
  } tpioc_func_t;
  typedef struct packed {
    logic inMode;
    logic outToggle;
    tpioc_func_t func;
  } tpioc_sel_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tpioc_bus_t;
endpackage

//--- tpioc_timer_pin_io_control.sv
// Pad control and timers for the two general-purpose timer pins.
// Assumes pad inputs synchronous to ref_clk and a strobe register port.
`timescale 1ns/10ps
`default_nettype none
`include "tpioc_regs.svh"
module tpioc_timer_pin_io_control
  import tpioc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire tpioc_bus_t bus,
  output logic [31:0] rdata,
  input wire logic testRst_n,
  input wire logic emulationPinZero,
  input wire logic emulationPinOne,
  input wire logic [1:0] timerPinIn,
  output logic [1:0] timerPinOut,
  output logic [1:0] timerPinOe_n
);
  // Fields per pin: bit 0..1 func, bit 2 toggle, bit 3 input mode.
  tpioc_sel_t sel [2];
  tpioc_sel_t next_sel [2];
  logic [1:0] gpioOut, next_gpioOut;
  logic [15:0] period [2];
  logic [15:0] next_period [2];
  logic [15:0] count [2];
  logic [15:0] next_count [2];
  logic [1:0] pinQ, next_pinQ;
  logic [1:0] pinLast, next_pinLast;
  logic [1:0] pinOut, next_pinOut;
  logic [31:0] next_rdata;
  logic [1:0] match;
  logic offMode;

  // OFF is a pad-level state, so it acts without the clock.
  assign offMode = !testRst_n && emulationPinZero && !emulationPinOne;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gPin
      always_comb begin
        next_sel[g] = sel[g];
        next_period[g] = period[g];
        if (bus.wr && bus.addr == `TPIOC_OFF_SELECT) begin
          next_sel[g] = bus.wdata[g*4 +: 4];
        end
        if (bus.wr && bus.addr == (g ? `TPIOC_OFF_PERIOD1
                                      : `TPIOC_OFF_PERIOD0)) begin
          next_period[g] = bus.wdata[15:0];
        end
      end

      // Counter advances on the rising pin edge, or on level, or freely.
      always_comb begin
        logic adv;
        adv = 1'b1;
        if (sel[g].func == TPIOC_TIM_IN) begin
          if (!sel[g].inMode) begin
            adv = pinQ[g] && !pinLast[g];
          end else begin
            adv = pinQ[g];
          end
        end
        match[g] = adv && (count[g] == period[g]);
        next_count[g] = count[g];
        if (adv) begin
          next_count[g] = match[g] ? 16'h0000 : count[g] + 16'h0001;
        end
        // The toggle holds its level between matches; pulse lasts one cycle.
        next_pinOut[g] = sel[g].outToggle ? (pinOut[g] ^ match[g])
                                          : match[g];
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          sel[g] <= `TPIOC_SEL_RESET;
          period[g] <= `TPIOC_PERIOD_RESET;
          count[g] <= 16'h0000;
        end else if (clkEn) begin
          sel[g] <= next_sel[g];
          period[g] <= next_period[g];
          count[g] <= next_count[g];
        end
      end

      // Driver enable is gated by reset directly so the pad floats at once.
      always_comb begin
        timerPinOe_n[g] = 1'b1;
        timerPinOut[g] = 1'b0;
        if (rst_n && !offMode) begin
          if (sel[g].func == TPIOC_GPIO_OUT) begin
            timerPinOe_n[g] = 1'b0;
            timerPinOut[g] = gpioOut[g];
          end else if (sel[g].func == TPIOC_TIM_OUT) begin
            timerPinOe_n[g] = 1'b0;
            timerPinOut[g] = pinOut[g];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    next_gpioOut = gpioOut;
    if (bus.wr && bus.addr == `TPIOC_OFF_GPIO_OUT) begin
      next_gpioOut = bus.wdata[1:0];
    end
    next_pinQ = timerPinIn;
    next_pinLast = pinQ;
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `TPIOC_OFF_SELECT: next_rdata = {24'h00_0000, sel[1], sel[0]};
        `TPIOC_OFF_GPIO_OUT: next_rdata = {30'h0, gpioOut};
        `TPIOC_OFF_GPIO_IN: next_rdata = {30'h0, pinQ};
        `TPIOC_OFF_PERIOD0: next_rdata = {16'h0000, period[0]};
        `TPIOC_OFF_COUNT0: next_rdata = {16'h0000, count[0]};
        `TPIOC_OFF_PERIOD1: next_rdata = {16'h0000, period[1]};
        `TPIOC_OFF_COUNT1: next_rdata = {16'h0000, count[1]};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gpioOut <= 2'h0;
      pinQ <= 2'h0;
      pinLast <= 2'h0;
      pinOut <= 2'h0;
      rdata <= 32'h0000_0000;
    end else if (clkEn) begin
      gpioOut <= next_gpioOut;
      pinQ <= next_pinQ;
      pinLast <= next_pinLast;
      pinOut <= next_pinOut;
      rdata <= next_rdata;
    end
  end

  property p_reset_float;
    @(posedge ref_clk) !rst_n |-> timerPinOe_n == 2'h3;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("pin driven in reset");

  property p_off_float;
    @(posedge ref_clk) disable iff (!rst_n) offMode |-> timerPinOe_n == 2'h3;
  endproperty
  a_off_float: assert property (p_off_float)
    else $error("pin driven in OFF");

  property p_default_input;
    @(posedge ref_clk) !rst_n ##1 rst_n && !bus.wr |-> timerPinOe_n == 2'h3;
  endproperty
  a_default_input: assert property (p_default_input)
    else $error("not input after reset");

  property p_sel_write;
    @(posedge ref_clk) disable iff (!rst_n)
      bus.wr && clkEn && bus.addr == `TPIOC_OFF_SELECT
      |=> sel[0] == $past(bus.wdata[3:0]) && sel[1] == $past(bus.wdata[7:4]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select not stored");

  property p_gpio_drive;
    @(posedge ref_clk) disable iff (!rst_n)
      !offMode && sel[0].func == TPIOC_GPIO_OUT
      |-> !timerPinOe_n[0] && timerPinOut[0] == gpioOut[0];
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("gpio not driven");

  property p_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && match[0] && !sel[0].outToggle ##1 !sel[0].outToggle
      |-> pinOut[0];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("no pulse on match");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && sel[1].func == TPIOC_TIM_IN && sel[1].inMode && !pinQ[1]
      && !(bus.wr && bus.addr == `TPIOC_OFF_SELECT) |=> $stable(count[1]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("count ran while gated");

  property p_extclk;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && sel[1].func == TPIOC_TIM_IN && !sel[1].inMode
      && pinQ[1] == pinLast[1] |=> $stable(count[1]);
  endproperty
  a_extclk: assert property (p_extclk)
    else $error("count without pin edge");

  // Several steps of the pin behaviour are named once and reused below.
  sequence s_match_pulse0;
    clkEn && match[0] && !sel[0].outToggle;
  endsequence
  sequence s_match_toggle0;
    clkEn && match[0] && sel[0].outToggle;
  endsequence
  sequence s_ext_edge1;
    clkEn && sel[1].func == TPIOC_TIM_IN && !sel[1].inMode
    && pinQ[1] && !pinLast[1] && count[1] != period[1];
  endsequence
  sequence s_gate_open1;
    clkEn && sel[1].func == TPIOC_TIM_IN && sel[1].inMode && pinQ[1]
    && count[1] != period[1];
  endsequence

  property p_toggle0;
    @(posedge ref_clk) disable iff (!rst_n)
      s_match_toggle0 |=> pinOut[0] != $past(pinOut[0]);
  endproperty
  a_toggle0: assert property (p_toggle0)
    else $error("no toggle on match");

  property p_pulse_end0;
    @(posedge ref_clk) disable iff (!rst_n)
      s_match_pulse0 ##1 (clkEn && !match[0] && !sel[0].outToggle)
      |=> !pinOut[0];
  endproperty
  a_pulse_end0: assert property (p_pulse_end0)
    else $error("pulse longer than one cycle");

  property p_wrap0;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && match[0] |=> count[0] == 16'h0000;
  endproperty
  a_wrap0: assert property (p_wrap0)
    else $error("count zero not cleared on match");

  property p_wrap1;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && match[1] |=> count[1] == 16'h0000;
  endproperty
  a_wrap1: assert property (p_wrap1)
    else $error("count one not cleared on match");

  property p_timer_drive0;
    @(posedge ref_clk) disable iff (!rst_n)
      !offMode && sel[0].func == TPIOC_TIM_OUT
      |-> !timerPinOe_n[0] && timerPinOut[0] == pinOut[0];
  endproperty
  a_timer_drive0: assert property (p_timer_drive0)
    else $error("timer output not driven");

  property p_ext_step1;
    @(posedge ref_clk) disable iff (!rst_n)
      s_ext_edge1 |=> count[1] == $past(count[1]) + 16'h0001;
  endproperty
  a_ext_step1: assert property (p_ext_step1)
    else $error("pin edge not counted");

  property p_gate_run1;
    @(posedge ref_clk) disable iff (!rst_n)
      s_gate_open1 |=> count[1] == $past(count[1]) + 16'h0001;
  endproperty
  a_gate_run1: assert property (p_gate_run1)
    else $error("count stopped while gate open");

  property p_gpio_read;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && bus.rd && bus.addr == `TPIOC_OFF_GPIO_IN
      |=> rdata == {30'h0, $past(pinQ)};
  endproperty
  a_gpio_read: assert property (p_gpio_read)
    else $error("gpio input read wrong");

  property p_gpio_store;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && bus.wr && bus.addr == `TPIOC_OFF_GPIO_OUT
      |=> gpioOut == $past(bus.wdata[1:0]);
  endproperty
  a_gpio_store: assert property (p_gpio_store)
    else $error("gpio output not stored");

  property p_reset_sel;
    @(posedge ref_clk)
      !rst_n |=> sel[0] == `TPIOC_SEL_RESET && sel[1] == `TPIOC_SEL_RESET;
  endproperty
  a_reset_sel: assert property (p_reset_sel)
    else $error("select not cleared by reset");

  property p_in_float0;
    @(posedge ref_clk) disable iff (!rst_n)
      sel[0].func == TPIOC_GPIO_IN || sel[0].func == TPIOC_TIM_IN
      |-> timerPinOe_n[0];
  endproperty
  a_in_float0: assert property (p_in_float0)
    else $error("input pin zero driven");

  property p_in_float1;
    @(posedge ref_clk) disable iff (!rst_n)
      sel[1].func == TPIOC_GPIO_IN || sel[1].func == TPIOC_TIM_IN
      |-> timerPinOe_n[1];
  endproperty
  a_in_float1: assert property (p_in_float1)
    else $error("input pin one driven");

  property p_mixed;
    @(posedge ref_clk) disable iff (!rst_n)
      !offMode && sel[0].func == TPIOC_GPIO_OUT
      && sel[1].func == TPIOC_GPIO_IN |-> timerPinOe_n == 2'h2;
  endproperty
  a_mixed: assert property (p_mixed)
    else $error("pins not set apart");

  property p_period1;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && bus.wr && bus.addr == `TPIOC_OFF_PERIOD1
      |=> period[1] == $past(bus.wdata[15:0]);
  endproperty
  a_period1: assert property (p_period1)
    else $error("period one not stored");

  // A frozen clock enable must not let a pin edge slip into the count.
  property p_freeze;
    @(posedge ref_clk) disable iff (!rst_n)
      !clkEn |=> $stable(count[1]) && $stable(sel[1]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      clkEn && !bus.rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read");

  property p_reset_count;
    @(posedge ref_clk)
      !rst_n |=> count[0] == 16'h0000 && count[1] == 16'h0000;
  endproperty
  a_reset_count: assert property (p_reset_count)
    else $error("count not cleared by reset");
endmodule
`default_nettype wire

//--- tpioc_pad_model.sv
// Board model that drives the two timer pads from outside.
// Assumes the device output enables are active low.
`timescale 1ns/10ps
`default_nettype none
module tpioc_pad_model (
  input wire logic ref_clk,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe_n,
  output logic [1:0] pinLevel
);
  logic [1:0] ext = 2'b00;
  // A driving device wins the pad, so the board level only shows otherwise.
  assign pinLevel = (pinOut & ~pinOe_n) | (ext & pinOe_n);
  task automatic edges(input int pin, input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge ref_clk);
      ext[pin] <= 1'b1;
      repeat (gap) @(posedge ref_clk);
      ext[pin] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- tpioc_timer_pin_io_control_test.sv
// Self-checking bench for the timer pin I/O control block.
// Assumes the pad model and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tpioc_regs.svh"
module tpioc_timer_pin_io_control_test;
  import tpioc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic testRst_n = 1'b1;
  logic emuZero = 1'b0;
  logic emuOne = 1'b1;
  logic clkEn = 1'b1;
  tpioc_bus_t bus = '0;
  logic [31:0] rdata, gpo, per;
  logic [1:0] pinIn, pinOut, pinOe_n;
  logic rdLag = 1'b0;
  logic [31:0] expQ[$];
  int fail_count = 0;
  int n_compared = 0;
  int gap;
  always #20 ref_clk = ~ref_clk;
  tpioc_timer_pin_io_control dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .clkEn(clkEn), .bus(bus), .rdata(rdata), .testRst_n(testRst_n),
    .emulationPinZero(emuZero), .emulationPinOne(emuOne),
    .timerPinIn(pinIn), .timerPinOut(pinOut), .timerPinOe_n(pinOe_n));
  tpioc_pad_model pad_u (.ref_clk(ref_clk), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .pinLevel(pinIn));
  task automatic cmp(input string what, input logic [31:0] e,
                     input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
  endtask
  // Read data stand for one cycle only, so they are looked at mid-cycle.
  always @(posedge ref_clk) rdLag <= bus.rd;
  always @(negedge ref_clk) if (rdLag) cmp("rdata", expQ.pop_front(), rdata);
  // Distance between pulses, or between level changes in toggle mode.
  task automatic spacing(input bit tog, output int d);
    int t;
    logic prev;
    t = -1;
    d = 0;
    @(negedge ref_clk);
    prev = pinOut[0];
    for (int k = 0; k < 64 && d == 0; k++) begin
      @(negedge ref_clk);
      if (tog ? pinOut[0] !== prev : pinOut[0] === 1'b1) begin
        if (t >= 0) d = k - t;
        t = k;
      end
      prev = pinOut[0];
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hecac90e4));
    repeat (8) @(posedge ref_clk);
    cmp("oe in reset", 32'h3, {30'h0, pinOe_n});
    rst_n <= 1'b1;
    rd(`TPIOC_OFF_SELECT, 32'h0);
    cmp("oe idle", 32'h3, {30'h0, pinOe_n});
    gpo = $urandom;
    pad_u.ext[1] <= gpo[1];
    wr(`TPIOC_OFF_GPIO_OUT, gpo);
    wr(`TPIOC_OFF_SELECT, 32'h1);
    @(negedge ref_clk);
    cmp("oe mixed", 32'h2, {30'h0, pinOe_n});
    cmp("gpio out", {31'h0, gpo[0]}, {31'h0, pinOut[0]});
    rd(`TPIOC_OFF_GPIO_IN, {30'h0, gpo[1:0]});
    @(posedge ref_clk);
    testRst_n <= 1'b0;
    emuZero <= 1'b1;
    emuOne <= 1'b0;
    @(negedge ref_clk);
    cmp("oe off", 32'h3, {30'h0, pinOe_n});
    @(posedge ref_clk);
    testRst_n <= 1'b1;
    @(negedge ref_clk);
    cmp("oe not off", 32'h2, {30'h0, pinOe_n});
    // A second reset restarts count zero so the short period is met soon.
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    cmp("oe in reset 2", 32'h3, {30'h0, pinOe_n});
    rst_n <= 1'b1;
    per = 32'($urandom_range(9, 2));
    wr(`TPIOC_OFF_PERIOD0, per);
    wr(`TPIOC_OFF_SELECT, 32'h2);
    spacing(1'b0, gap);
    cmp("pulse spacing", per + 32'h1, 32'(gap));
    wr(`TPIOC_OFF_SELECT, 32'h6);
    spacing(1'b1, gap);
    cmp("toggle spacing", per + 32'h1, 32'(gap));
    pad_u.ext[1] <= 1'b0;
    wr(`TPIOC_OFF_PERIOD1, 32'h0);
    // Count one must wrap round before it meets the zero period.
    repeat (65540) @(posedge ref_clk);
    wr(`TPIOC_OFF_SELECT, 32'h30);
    wr(`TPIOC_OFF_PERIOD1, 32'hffff);
    pad_u.edges(1, 5, 1);
    repeat (4) @(posedge ref_clk);
    rd(`TPIOC_OFF_COUNT1, 32'h5);
    wr(`TPIOC_OFF_SELECT, 32'hb0);
    @(posedge ref_clk);
    pad_u.ext[1] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pad_u.ext[1] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clkEn <= 1'b0;
    pad_u.ext[1] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pad_u.ext[1] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    clkEn <= 1'b1;
    rd(`TPIOC_OFF_COUNT1, 32'hb);
    repeat (2) @(posedge ref_clk);
    final_report();
  end
endmodule
`default_nettype wire
